// *** hdl/cida_pkg.sv ***
/*
 * cida_pkg: constants for the configuration index/data access block.
 * assumes: a single-clock host bridge with 32-bit I/O port accesses.
 */
package cida_pkg;
    // I/O port addresses
    localparam logic [15:0] CIDA_PORT_INDEX = 16'h0cf8;
    localparam logic [15:0] CIDA_PORT_DATA = 16'h0cfc;
    // index register fields
    localparam int CIDA_ENABLE_BIT = 31;
    localparam int CIDA_BUS_LSB = 16;
    localparam int CIDA_BUS_MSB = 23;
    localparam int CIDA_DEV_LSB = 11;
    localparam int CIDA_DEV_MSB = 15;
    localparam int CIDA_FUNC_LSB = 8;
    localparam int CIDA_FUNC_MSB = 10;
    localparam int CIDA_REG_LSB = 2;
    localparam int CIDA_REG_MSB = 7;
    localparam logic [31:0] CIDA_INDEX_WMASK = 32'h80ff_fffc;
    localparam logic [31:0] CIDA_INDEX_RESET = 32'h0000_0000;
    // node device numbers on bus 0
    localparam logic [7:0] CIDA_NODE_BUS = 8'h00;
    localparam logic [4:0] CIDA_NODE_DEV_FIRST = 5'h18;
    localparam logic [2:0] CIDA_NODE_FUNC = 3'h0;
    // link type register byte offsets within function 0
    localparam logic [7:0] CIDA_LINK0_OFS = 8'h98;
    localparam logic [7:0] CIDA_LINK1_OFS = 8'hb8;
    localparam logic [7:0] CIDA_LINK2_OFS = 8'hd8;
    localparam logic [7:0] CIDA_LINK3_OFS = 8'hf8;
    // link type register bit positions, then link and node counts and status width
    localparam int CIDA_LT_CONNECTED = 0;
    localparam int CIDA_LT_INIT_DONE = 1;
    localparam int CIDA_LT_NONCOH = 2;
    localparam int CIDA_LT_PENDING = 4;
    localparam int CIDA_LINKS = 4;
    localparam int CIDA_NODES = 8;
    localparam int CIDA_STAT_W = 4;
    // value returned by a config read that hits nothing
    localparam logic [31:0] CIDA_MISS_DATA = 32'hffff_ffff;
endpackage

// *** hdl/cida_link_regs.sv ***
/*
 * cida_link_regs: combinational link type register view of all nodes.
 * assumes: status inputs already synchronised to the reference clock.
 */
`timescale 1ns/10ps
module cida_link_regs #(
    parameter int NODES = 8,
    parameter int LINKS = 4
) (
    // per node, per link: {pending, noncoherent, init done, connected}
    input wire logic [NODES*LINKS*4-1:0] i_link_stat,
    // decoded target
    input wire logic [4:0] i_dev,
    input wire logic [5:0] i_dword,
    // result
    output logic o_hit,
    output logic [31:0] o_data
);
    import cida_pkg::*;

    function automatic logic [31:0] cida_fmt(input logic [3:0] s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[CIDA_LT_CONNECTED] = s[0];
        w[CIDA_LT_INIT_DONE] = s[1];
        w[CIDA_LT_NONCOH] = s[2];
        w[CIDA_LT_PENDING] = s[3];
        return w;
    endfunction

    logic [7:0] link_ofs [LINKS];
    assign link_ofs[0] = CIDA_LINK0_OFS;
    assign link_ofs[1] = CIDA_LINK1_OFS;
    assign link_ofs[2] = CIDA_LINK2_OFS;
    assign link_ofs[3] = CIDA_LINK3_OFS;

    always_comb begin
        logic [4:0] node;
        logic [7:0] ofs;
        node = i_dev - CIDA_NODE_DEV_FIRST;
        ofs = {i_dword, 2'b00};
        o_hit = 1'b0;
        o_data = 32'h0000_0000;
        if (i_dev >= CIDA_NODE_DEV_FIRST &&
                32'(node) < NODES) begin
            for (int l = 0; l < LINKS; l++) begin
                if (ofs == link_ofs[l]) begin
                    o_hit = 1'b1;
                    o_data = cida_fmt(i_link_stat[
                        (32'(node) * LINKS + l) * 4 +: 4]);
                end
            end
        end
    end
endmodule

// *** hdl/cida_top.sv ***
/*
 * cida_top: configuration index/data I/O port pair with node link status.
 * assumes: one 32-bit I/O access per request pulse; link status pins
 * come from another domain and are synchronised here.
 */
`timescale 1ns/10ps
// Operation
// - index register decoded at I/O port 16'h0cf8, holds next target.
// - data register at I/O port 16'h0cfc accesses the indexed register.
// - index bit 31 must be set for data access to reach config space.
// - index fields: bus 23-16, device 15-11, function 10-8, dword 7-2.
// - up to eight nodes answer as bus 0 devices 18h-1Fh, function 0.
// - link type registers at 98h, B8h, D8h, F8h for links 0-3.
// - bit 0 connected and bit 2 noncoherent are read-only status.
module cida_top #(
    parameter int NODES = cida_pkg::CIDA_NODES,
    parameter int LINKS = cida_pkg::CIDA_LINKS
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // processor I/O port access
    input wire logic i_io_req,
    input wire logic i_io_wr,
    input wire logic [15:0] i_io_addr,
    input wire logic [31:0] i_io_wdata,
    output logic o_io_ack,
    output logic [31:0] o_io_rdata,
    // node link status pins
    input wire logic [NODES*LINKS*cida_pkg::CIDA_STAT_W-1:0] i_link_stat,
    // ordinary I/O forward
    output logic o_fwd_req,
    output logic o_fwd_wr,
    output logic [15:0] o_fwd_addr,
    output logic [31:0] o_fwd_wdata,
    input wire logic i_fwd_ack,
    input wire logic [31:0] i_fwd_rdata,
    // configuration cycle monitor
    output logic o_cfg_cycle,
    output logic [31:0] o_index
);
    import cida_pkg::*;

    localparam int SW = NODES * LINKS * CIDA_STAT_W;

    typedef enum logic [1:0] {
        CIDA_IDLE = 2'b00,
        CIDA_FWD = 2'b01
    } cida_state_t;

    typedef struct packed {
        cida_state_t st;
        logic [31:0] index;
        logic ack;
        logic [31:0] rdata;
        logic fwd_req;
        logic fwd_wr;
        logic [15:0] fwd_addr;
        logic [31:0] fwd_wdata;
        logic cfg;
        logic [SW-1:0] s1;
        logic [SW-1:0] s2;
    } cida_regs_t;

    cida_regs_t r_q;
    cida_regs_t r_d;
    logic lr_hit;
    logic [31:0] lr_data;

    ////////////////////////////////////////////////////////////////////
    cida_link_regs #(
        .NODES(NODES),
        .LINKS(LINKS)
    ) u_link (
        .i_link_stat(r_q.s2),
        .i_dev(r_q.index[CIDA_DEV_MSB:CIDA_DEV_LSB]),
        .i_dword(r_q.index[CIDA_REG_MSB:CIDA_REG_LSB]),
        .o_hit(lr_hit),
        .o_data(lr_data)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic en;
        logic tgt;
        en = r_q.index[CIDA_ENABLE_BIT];
        tgt = lr_hit &&
            r_q.index[CIDA_BUS_MSB:CIDA_BUS_LSB] == CIDA_NODE_BUS &&
            r_q.index[CIDA_FUNC_MSB:CIDA_FUNC_LSB] == CIDA_NODE_FUNC;
        r_d = r_q;
        // two-flop sync of link status pins
        r_d.s1 = i_link_stat;
        r_d.s2 = r_q.s1;
        r_d.ack = 1'b0;
        r_d.cfg = 1'b0;
        case (r_q.st)
            CIDA_IDLE: begin
                if (i_io_req && i_io_addr == CIDA_PORT_INDEX) begin
                    if (i_io_wr) begin
                        r_d.index = i_io_wdata & CIDA_INDEX_WMASK;
                    end
                    r_d.rdata = r_q.index;
                    r_d.ack = 1'b1;
                end else if (i_io_req && i_io_addr == CIDA_PORT_DATA &&
                        en) begin
                    r_d.cfg = 1'b1;
                    r_d.rdata = tgt ? lr_data : CIDA_MISS_DATA;
                    r_d.ack = 1'b1;
                end else if (i_io_req) begin
                    r_d.fwd_req = 1'b1;
                    r_d.fwd_wr = i_io_wr;
                    r_d.fwd_addr = i_io_addr;
                    r_d.fwd_wdata = i_io_wdata;
                    r_d.st = CIDA_FWD;
                end
            end
            CIDA_FWD: begin
                if (i_fwd_ack) begin
                    r_d.fwd_req = 1'b0;
                    r_d.rdata = i_fwd_rdata;
                    r_d.ack = 1'b1;
                    r_d.st = CIDA_IDLE;
                end
            end
            default: begin
                r_d.st = CIDA_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign o_io_ack = r_q.ack;
    assign o_io_rdata = r_q.rdata;
    assign o_fwd_req = r_q.fwd_req;
    assign o_fwd_wr = r_q.fwd_wr;
    assign o_fwd_addr = r_q.fwd_addr;
    assign o_fwd_wdata = r_q.fwd_wdata;
    assign o_cfg_cycle = r_q.cfg;
    assign o_index = r_q.index;

    ////////////////////////////////////////////////////////////////////
    AST_INDEX_WRITE:
    assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        r_q.st == CIDA_IDLE && i_io_req && i_io_wr &&
        i_io_addr == CIDA_PORT_INDEX |=>
        o_index == ($past(i_io_wdata) & CIDA_INDEX_WMASK) && o_io_ack)
        else $error("index write not captured");

    AST_DATA_CFG:
    assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        r_q.st == CIDA_IDLE && i_io_req &&
        i_io_addr == CIDA_PORT_DATA && o_index[31] |=>
        o_cfg_cycle && o_io_ack && !o_fwd_req)
        else $error("data access made no config cycle");

    AST_ENABLE_GATES:
    assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        o_cfg_cycle |-> $past(o_index[31]))
        else $error("config cycle without enable");

    AST_RESERVED_ZERO:
    assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        o_index[30:24] == 7'h00 && o_index[1:0] == 2'h0)
        else $error("reserved index bits set");

    AST_NODE_RANGE:
    assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        lr_hit |-> r_q.index[15:11] >= 5'h18)
        else $error("hit outside node devices");

    AST_LINK_OFS:
    assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        lr_hit |-> r_q.index[4:2] == 3'h6)
        else $error("hit at non link offset");

    AST_STATUS_LAYOUT:
    assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        lr_hit |-> lr_data[31:5] == 27'h0 && lr_data[3] == 1'b0)
        else $error("reserved status bits set");

    AST_WRITE_IGNORED:
    assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        o_cfg_cycle |-> $stable(o_index))
        else $error("data write disturbed index");

    AST_FORWARD:
    assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        r_q.st == CIDA_IDLE && i_io_req &&
        i_io_addr == CIDA_PORT_DATA && !o_index[31] |=>
        o_fwd_req && o_fwd_addr == CIDA_PORT_DATA && !o_cfg_cycle)
        else $error("disabled data access not forwarded");

    AST_INDEX_READ:
    assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        r_q.st == CIDA_IDLE && i_io_req && !i_io_wr &&
        i_io_addr == CIDA_PORT_INDEX |=>
        o_io_rdata == $past(o_index) && o_io_ack)
        else $error("index read returned wrong value");

    AST_MISS_DATA:
    assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        r_q.st == CIDA_IDLE && i_io_req && o_index[31] &&
        i_io_addr == CIDA_PORT_DATA && o_index[23:16] != 8'h00 |=>
        o_io_rdata == CIDA_MISS_DATA)
        else $error("other bus read did not miss");

    AST_FWD_HOLD:
    assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        o_fwd_req && !i_fwd_ack |=>
        o_fwd_req && $stable(o_fwd_addr))
        else $error("forward request dropped early");
endmodule

// *** bench/cida_fwd_model.sv ***
/*
 * cida_fwd_model: ordinary I/O target behind the forward port.
 * assumes: driven off the falling edge; delay set by the bench.
 */
`timescale 1ns/10ps
module cida_fwd_model (
    // clock and delay
    input wire logic i_clk,
    input wire logic [3:0] i_dly,
    // forward request
    input wire logic i_req,
    input wire logic [15:0] i_addr,
    output logic o_ack,
    output logic [31:0] o_rdata
);
    logic [3:0] cnt = 4'h0;
    logic ack_q = 1'b0;
    logic [31:0] rd_q = 32'h0;
    assign o_ack = ack_q;
    assign o_rdata = rd_q;
    // idle data toggles so a stale sample shows
    always @(negedge i_clk) begin
        ack_q <= 1'b0;
        rd_q <= ~rd_q;
        cnt <= 4'h0;
        if (i_req && !ack_q) begin
            cnt <= cnt + 4'h1;
            if (cnt >= i_dly) begin
                ack_q <= 1'b1;
                rd_q <= {16'h5a00, i_addr};
            end
        end
    end
endmodule

// *** bench/testbench.sv ***
/*
 * testbench: index/data port accesses against cida_top.
 * assumes: default 8 nodes, 4 links; forward target is cida_fwd_model.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    n_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench;
    import cida_pkg::*;
    typedef struct {logic [31:0] idx; logic [31:0] exp;} cida_row_t;
    logic clk = 0, resetn = 0, req = 0, wr = 0, fack, ack, fwd, cfg;
    logic [15:0] addr = 16'h0, faddr, fa;
    logic [31:0] wdata = 32'h0, frd, rdata, index, rd, fwdat, fd;
    logic [127:0] lst;
    logic [3:0] dly = 4'h1;
    logic cf, fwr, fw;
    int n_errors = 0, check_count = 0;
    cida_row_t rows[8];
    cida_top i_cida_top (.i_ref_clk(clk), .i_resetn(resetn),
        .i_io_req(req), .i_io_wr(wr), .i_io_addr(addr),
        .i_io_wdata(wdata), .o_io_ack(ack), .o_io_rdata(rdata),
        .i_link_stat(lst), .o_fwd_req(fwd), .o_fwd_wr(fwr),
        .o_fwd_addr(faddr), .o_fwd_wdata(fwdat), .i_fwd_ack(fack),
        .i_fwd_rdata(frd), .o_cfg_cycle(cfg), .o_index(index));
    cida_fwd_model i_cida_fwd_model (.i_clk(clk), .i_dly(dly),
        .i_req(fwd), .i_addr(faddr), .o_ack(fack), .o_rdata(frd));
    initial begin
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] lt(int k);
        logic [3:0] b;
        b = lst[k*4 +: 4];
        return {27'h0, b[3], 1'b0, b[2:0]};
    endfunction
    function automatic logic [31:0] ix(int n, int l);
        return 32'h8000_0000 | (32'(8'h18 + n) << 11) | 32'(8'h98 + l * 32);
    endfunction
    // one whole access: one-cycle request pulse, then wait for acknowledge
    task automatic io(input logic w, input logic [15:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        fa = 16'h0;
        fw = 1'b0;
        fd = 32'h0;
        req = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        @(negedge clk);
        req = 1'b0;
        while (ack !== 1'b1 && k < 40) begin
            if (fwd === 1'b1) begin
                fa = faddr;
                fw = fwr;
                fd = fwdat;
            end
            @(negedge clk);
            k++;
        end
        `CHK("ack", 1'b1, ack)
        rd = rdata;
        cf = cfg;
        // idle cycle so the next request is a fresh pulse
        @(negedge clk);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    initial begin
        for (int i = 0; i < 32; i++) lst[i*4 +: 4] = 4'(i) ^ 4'h5;
        for (int l = 0; l < 4; l++) rows[l] = '{ix(0, l), lt(l)};
        rows[4] = '{ix(7, 3), lt(31)};
        rows[5] = '{ix(0, 0) | 32'h100, CIDA_MISS_DATA};
        rows[6] = '{ix(0, 0) | 32'h1_0000, CIDA_MISS_DATA};
        rows[7] = '{32'h8000_b898, CIDA_MISS_DATA};
        repeat (4) @(negedge clk);
        `CHK("index rst", 32'h0, index)
        `CHK("fwd rst", 1'b0, fwd)
        resetn = 1'b1;
        @(negedge clk);
        foreach (rows[i]) begin
            // index then data, as a pair
            io(1'b1, 16'h0cf8, rows[i].idx);
            `CHK("index", rows[i].idx, index)
            io(1'b0, 16'h0cfc, 32'h0);
            `CHK("cfg data", rows[i].exp, rd)
            `CHK("cfg cycle", 1'b1, cf)
        end
        $display("test table done");
        io(1'b1, 16'h0cf8, 32'hffff_ffff);
        `CHK("index mask", 32'h80ff_fffc, index)
        io(1'b1, 16'h0cf8, ix(0, 2));
        io(1'b0, 16'h0cf8, 32'h0);
        `CHK("index read", ix(0, 2), rd)
        io(1'b1, 16'h0cfc, 32'hffff_ffff);
        io(1'b0, 16'h0cfc, 32'h0);
        `CHK("ro data", lt(2), rd)
        lst = ~lst;
        repeat (3) @(negedge clk);
        io(1'b0, 16'h0cfc, 32'h0);
        `CHK("live status", lt(2), rd)
        $display("test status done");
        io(1'b1, 16'h0cf8, ix(0, 0) & 32'h7fff_ffff);
        `CHK("index off", 32'h0000_c098, index)
        io(1'b0, 16'h0cfc, 32'h0);
        `CHK("fwd addr", 16'h0cfc, fa)
        `CHK("fwd rd", 1'b0, fw)
        `CHK("fwd data", 32'h5a00_0cfc, rd)
        `CHK("no cfg", 1'b0, cf)
        dly = 4'h6;
        io(1'b1, 16'h0060, 32'h1234_5678);
        `CHK("slow fwd addr", 16'h0060, fa)
        `CHK("slow fwd wr", 1'b1, fw)
        `CHK("slow fwd data", 32'h1234_5678, fd)
        $display("test forward done");
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("index rst2", 32'h0, index)
        `CHK("rdata rst2", 32'h0, rdata)
        `CHK("fwd rst2", 1'b0, fwd)
        resetn = 1'b1;
        @(negedge clk);
        io(1'b1, 16'h0cf8, ix(7, 1));
        io(1'b0, 16'h0cf8, 32'h0);
        `CHK("index after rst", ix(7, 1), rd)
        io(1'b0, 16'h0cfc, 32'h0);
        `CHK("data after rst", lt(29), rd)
        $display("test reset done");
        give_verdict();
    end
endmodule
